/* File: include/iar_pkg.sv */
// Package for the input alarm and relay logic: register map, field layout, reset values
// ==========================================================================
// Overview of operation
// - Each input has alarm enable, low and high setpoints; reset off, 0 K, 1000 K.
// - High alarm asserts when reading exceeds the high setpoint.
// - Low alarm asserts when reading is below the low setpoint.
// - Setpoint writes are clamped to the range of the input's preferred units.
// - Indicator lit steadily while any enabled alarm has its visible flag set.
// - Indicator flashes while any visible alarm is active.
// - A displayed input in alarm alternates status message and reading.
// - Beeper sounds when an enabled audible alarm becomes active; audible defaults on.
// - With latching on (default off) an alarm holds after the condition clears.
// - Only an accepted reset-alarm request or clearing the input's enable clears a latch; a declined request does nothing.
// - With latching off each alarm follows the current reading.
// - Non-latching high alarm clears at high setpoint minus dead band; default 1 K.
// - Non-latching low alarm clears at low setpoint plus dead band.
// - Two independent relays, each assignable to any input.
// - Off mode (default) leaves the relay drive deasserted.
// - On mode asserts the relay drive unconditionally.
// - Alarm mode, follow low: drive equals selected input's low alarm.
// - Alarm mode, follow high: drive equals selected input's high alarm.
// - Alarm mode, follow both (default): drive is low OR high alarm.
package iar_pkg;

  // Readings and setpoints: unsigned fixed point, 0.0001 K per count
  localparam int VAL_W = 24;
  localparam logic [VAL_W-1:0] LOW_SP_RST = 24'h000000;      // 0.0000 K
  localparam logic [VAL_W-1:0] HIGH_SP_RST = 24'h989680;     // 1000 K
  localparam logic [VAL_W-1:0] DEADBAND_RST = 24'h002710;    // 1.0000 K
  localparam logic [VAL_W-1:0] UNIT_MAX_RST = 24'hffffff;    // No unit limit until software sets one

  // ==========================================================================
  // Register map (byte addresses); per input block stride 0x20
  localparam logic [11:0] IN_STRIDE = 12'h020;
  localparam logic [11:0] OFF_IN_CFG = 12'h000;
  localparam logic [11:0] OFF_IN_LOW = 12'h004;
  localparam logic [11:0] OFF_IN_HIGH = 12'h008;
  localparam logic [11:0] OFF_IN_DB = 12'h00c;
  localparam logic [11:0] OFF_IN_MAX = 12'h010;
  localparam logic [11:0] OFF_IN_STAT = 12'h014;
  localparam logic [11:0] OFF_RELAY0 = 12'h080;
  localparam logic [11:0] OFF_RELAY1 = 12'h084;
  localparam logic [11:0] OFF_ALARM_CTL = 12'h088;
  localparam logic [11:0] OFF_SUMMARY = 12'h08c;

  // Input config fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_VIS_BIT = 1;
  localparam int CFG_AUD_BIT = 2;
  localparam int CFG_LATCH_BIT = 3;
  localparam logic [3:0] CFG_RST = 4'h6;                     // visible and audible on

  // Relay fields
  localparam int RLY_MODE_LSB = 0;
  localparam int RLY_SRC_LSB = 2;
  localparam int RLY_FOL_LSB = 4;

  // Alarm control fields (write one to act)
  localparam int CTL_RESET_BIT = 0;
  localparam int CTL_BEEP_ACK_BIT = 1;

  // Half period of indicator flash and display alternation, in cycles of the 40 MHz clock
  localparam int CLK_HZ = 40_000_000;
  localparam int BLINK_MS = 500;
  localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int BLINK_W = 25;

  typedef enum logic [1:0] {RLY_OFF, RLY_ON, RLY_ALARM} iar_rly_mode_t;
  typedef enum logic [1:0] {FOL_LOW, FOL_HIGH, FOL_BOTH} iar_follow_t;

  typedef struct packed {
    iar_follow_t follow;
    logic [1:0] src;
    iar_rly_mode_t mode;
  } iar_relay_cfg_t;

  typedef struct packed {
    logic latch;
    logic audible;
    logic visible;
    logic enable;
  } iar_in_cfg_t;

  localparam iar_relay_cfg_t RELAY_RST = '{follow: FOL_BOTH, src: 2'h0, mode: RLY_OFF};

endpackage

/* File: rtl/iar_alarm_relay.sv */
// Alarm comparison, latching, annunciator, beeper and relay drive for four inputs
`timescale 1ns/1ps
module iar_alarm_relay
  import iar_pkg::*;
#(
  parameter int BLINK_CYCLES = BLINK_CYC
)
(
  input wire logic mclk,                        // System clock, 40 MHz
  input wire logic rst_b,                       // Asynchronous reset, active low
  input wire logic psel,                        // APB select
  input wire logic penable,                     // APB enable
  input wire logic pwrite,                      // APB write
  input wire logic [11:0] paddr,                // APB byte address
  input wire logic [31:0] pwdata,               // APB write data
  output logic [31:0] prdata,                   // APB read data
  output logic pready,                          // APB ready
  output logic pslverr,                         // APB error, unmapped address
  input wire logic [3:0] sampleValid,           // New reading strobe per input
  input wire logic [4*VAL_W-1:0] reading,       // Readings, input A in low bits
  input wire logic [1:0] displayedInput,        // Input shown on the front panel
  input wire logic displayActive,               // Front panel shows an input
  output logic alarmLed,                        // Alarm indicator drive
  output logic beeper,                          // Beeper drive
  output logic showAlarmMsg,                    // Display shows status instead of reading
  output logic [1:0] relayDrive                 // Relay coil drive, 1 energised
);

  // ==========================================================================
  // Register state
  iar_in_cfg_t inCfg_q [4];
  logic [VAL_W-1:0] lowSp_q [4];
  logic [VAL_W-1:0] highSp_q [4];
  logic [VAL_W-1:0] deadband_q [4];
  logic [VAL_W-1:0] unitMax_q [4];
  iar_relay_cfg_t relayCfg_q [2];
  logic [3:0] lowAlm_q;
  logic [3:0] highAlm_q;
  logic [3:0] lowAlm_d;
  logic [3:0] highAlm_d;
  logic beep_q;
  logic [BLINK_W-1:0] blinkCnt_q;
  logic blink_q;
  logic [1:0] relayDrive_q;

  logic wrEn;
  logic rdEn;
  logic [1:0] inIdx;
  logic [11:0] inOff;
  logic inSpace;
  logic mapped;
  logic resetReq;
  logic beepAck;
  logic [VAL_W-1:0] wrVal;
  logic [VAL_W-1:0] clampVal;
  logic [31:0] rdData;

  assign pready = 1'b1;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign inIdx = paddr[6:5];
  assign inOff = paddr & (IN_STRIDE - 12'h001);
  assign inSpace = paddr < OFF_RELAY0;
  assign wrVal = pwdata[VAL_W-1:0];
  assign clampVal = (wrVal > unitMax_q[inIdx]) ? unitMax_q[inIdx] : wrVal;
  assign resetReq = wrEn && (paddr == OFF_ALARM_CTL) && pwdata[CTL_RESET_BIT];
  assign beepAck = wrEn && (paddr == OFF_ALARM_CTL) && pwdata[CTL_BEEP_ACK_BIT];

  // ==========================================================================
  // Address decode
  always_comb
  begin
    mapped = 1'b1;
    rdData = 32'h00000000;
    if (inSpace && inOff == OFF_IN_CFG)
      rdData = {28'h0000000, inCfg_q[inIdx]};
    else if (inSpace && inOff == OFF_IN_LOW)
      rdData = {8'h00, lowSp_q[inIdx]};
    else if (inSpace && inOff == OFF_IN_HIGH)
      rdData = {8'h00, highSp_q[inIdx]};
    else if (inSpace && inOff == OFF_IN_DB)
      rdData = {8'h00, deadband_q[inIdx]};
    else if (inSpace && inOff == OFF_IN_MAX)
      rdData = {8'h00, unitMax_q[inIdx]};
    else if (inSpace && inOff == OFF_IN_STAT)
      rdData = {30'h00000000, highAlm_q[inIdx], lowAlm_q[inIdx]};
    else if (paddr == OFF_RELAY0)
      rdData = {26'h0000000, relayCfg_q[0]};
    else if (paddr == OFF_RELAY1)
      rdData = {26'h0000000, relayCfg_q[1]};
    else if (paddr == OFF_ALARM_CTL)
      rdData = 32'h00000000;
    else if (paddr == OFF_SUMMARY)
      rdData = {20'h00000, relayDrive_q, beep_q, alarmLed, highAlm_q, lowAlm_q};
    else
      mapped = 1'b0;
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rdData;
  end

  // ==========================================================================
  // Per-input configuration and alarm state
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : gInput
      logic [VAL_W-1:0] rd;
      logic hiTrip;
      logic loTrip;
      logic hiClear;
      logic loClear;
      logic [VAL_W:0] hiRel;
      logic [VAL_W:0] loRel;
      logic selHere;

      assign selHere = inSpace && (inIdx == 2'(gi));
      assign rd = reading[gi*VAL_W +: VAL_W];
      assign hiTrip = rd > highSp_q[gi];
      assign loTrip = rd < lowSp_q[gi];
      assign hiRel = {1'b0, highSp_q[gi]} - {1'b0, deadband_q[gi]};
      assign loRel = {1'b0, lowSp_q[gi]} + {1'b0, deadband_q[gi]};
      assign hiClear = hiRel[VAL_W] ? 1'b0 : ({1'b0, rd} <= hiRel);
      assign loClear = {1'b0, rd} >= loRel;

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          inCfg_q[gi] <= CFG_RST;
          lowSp_q[gi] <= LOW_SP_RST;
          highSp_q[gi] <= HIGH_SP_RST;
          deadband_q[gi] <= DEADBAND_RST;
          unitMax_q[gi] <= UNIT_MAX_RST;
        end
        else if (wrEn && selHere)
        begin
          if (inOff == OFF_IN_CFG)
            inCfg_q[gi] <= pwdata[3:0];
          else if (inOff == OFF_IN_LOW)
            lowSp_q[gi] <= clampVal;
          else if (inOff == OFF_IN_HIGH)
            highSp_q[gi] <= clampVal;
          else if (inOff == OFF_IN_DB)
            deadband_q[gi] <= wrVal;
          else if (inOff == OFF_IN_MAX)
            unitMax_q[gi] <= wrVal;
        end
      end

      // Hysteresis state follows the reading; a latch holds or sets, and clears on a reset request
      always_comb
      begin
        highAlm_d[gi] = highAlm_q[gi];
        lowAlm_d[gi] = lowAlm_q[gi];
        if (!inCfg_q[gi].enable)
        begin
          highAlm_d[gi] = 1'b0;
          lowAlm_d[gi] = 1'b0;
        end
        else if (sampleValid[gi])
        begin
          if (inCfg_q[gi].latch)
          begin
            highAlm_d[gi] = (highAlm_q[gi] & !resetReq) | hiTrip;
            lowAlm_d[gi] = (lowAlm_q[gi] & !resetReq) | loTrip;
          end
          else
          begin
            highAlm_d[gi] = hiTrip | (highAlm_q[gi] & !hiClear);
            lowAlm_d[gi] = loTrip | (lowAlm_q[gi] & !loClear);
          end
        end
        else if (resetReq && inCfg_q[gi].latch)
        begin
          highAlm_d[gi] = 1'b0;
          lowAlm_d[gi] = 1'b0;
        end
      end
    end
  endgenerate

  // A reset request meeting a sample still clears, but a trip in that sample sets the latch again
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      highAlm_q <= 4'h0;
      lowAlm_q <= 4'h0;
    end
    else
    begin
      highAlm_q <= highAlm_d;
      lowAlm_q <= lowAlm_d;
    end
  end

  // ==========================================================================
  // Annunciator, beeper and display alternation
  logic [3:0] enVis;
  logic [3:0] enAud;
  logic [3:0] active;
  logic [3:0] rising;
  logic anyVisEn;
  logic anyVisAct;

  generate
    for (gi = 0; gi < 4; gi++)
    begin : gFlags
      assign enVis[gi] = inCfg_q[gi].enable && inCfg_q[gi].visible;
      assign enAud[gi] = inCfg_q[gi].enable && inCfg_q[gi].audible;
    end
  endgenerate

  assign active = highAlm_q | lowAlm_q;
  assign rising = (highAlm_d | lowAlm_d) & ~active;
  assign anyVisEn = |enVis;
  assign anyVisAct = |(enVis & active);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      blinkCnt_q <= '0;
      blink_q <= 1'b0;
    end
    else if (blinkCnt_q == BLINK_W'(BLINK_CYCLES - 1))
    begin
      blinkCnt_q <= '0;
      blink_q <= !blink_q;
    end
    else
      blinkCnt_q <= blinkCnt_q + BLINK_W'(1);
  end

  // Flashing takes precedence over the steady enabled indication
  assign alarmLed = anyVisAct ? blink_q : anyVisEn;
  assign showAlarmMsg = displayActive && active[displayedInput] && blink_q;

  // Beeper stays on until software acknowledges or no enabled audible alarm is active; a new activation wins over the ack
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      beep_q <= 1'b0;
    else if (|(rising & enAud))
      beep_q <= 1'b1;
    else if (beepAck || !(|(active & enAud)))
      beep_q <= 1'b0;
  end
  assign beeper = beep_q;

  // ==========================================================================
  // Relays
  generate
    for (gi = 0; gi < 2; gi++)
    begin : gRelay
      logic lo;
      logic hi;
      assign lo = lowAlm_q[relayCfg_q[gi].src];
      assign hi = highAlm_q[relayCfg_q[gi].src];

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          relayCfg_q[gi] <= RELAY_RST;
        else if (wrEn && paddr == (gi == 0 ? OFF_RELAY0 : OFF_RELAY1))
          relayCfg_q[gi] <= pwdata[5:0];
      end

      always_ff @(posedge mclk or negedge rst_b)
      begin
        if (!rst_b)
          relayDrive_q[gi] <= 1'b0;
        else
        begin
          case (relayCfg_q[gi].mode)
            RLY_ON: relayDrive_q[gi] <= 1'b1;
            RLY_ALARM:
            begin
              case (relayCfg_q[gi].follow)
                FOL_LOW: relayDrive_q[gi] <= lo;
                FOL_HIGH: relayDrive_q[gi] <= hi;
                default: relayDrive_q[gi] <= lo | hi;
              endcase
            end
            default: relayDrive_q[gi] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  assign relayDrive = relayDrive_q;

endmodule

/* File: tb/iar_alarm_relay_assertions.sv */
// Port checker for the input alarm and relay logic
`timescale 1ns/1ps
module iar_alarm_relay_assertions
  import iar_pkg::*;
#(
  parameter int BLINK_CYCLES = 4
)
(
  input wire logic mclk, // Clock
  input wire logic rst_b, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic [3:0] sampleValid, // Sample strobes
  input wire logic [4*VAL_W-1:0] reading, // Readings
  input wire logic [1:0] displayedInput, // Shown input
  input wire logic displayActive, // Panel active
  input wire logic alarmLed, // Lamp
  input wire logic beeper, // Beeper
  input wire logic showAlarmMsg, // Status message
  input wire logic [1:0] relayDrive // Coils
);
  // ==========
  // Helper counters
  logic [2:0] evtAge_q;
  logic [24:0] msgRun_q;
  wire logic evt = (psel && penable && pwrite) || (|sampleValid);

  // Beeper and relay drive may only move shortly after a sample or a register write
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      evtAge_q <= 3'h0;
      msgRun_q <= 25'h0;
    end
    else
    begin
      evtAge_q <= evt ? 3'h0 : evtAge_q + {2'h0, evtAge_q != 3'h7};
      msgRun_q <= showAlarmMsg ? msgRun_q + 25'h1 : 25'h0;
    end
  end

  // ==========
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence accessPhase;
    psel && penable;
  endsequence
  sequence resetLeft;
    $rose(rst_b);
  endsequence

  ready_high_a: assert property (pready)
    else $error("pready low");
  err_access_a: assert property (pslverr |-> accessPhase)
    else $error("pslverr outside access phase");
  reset_quiet_a: assert property (resetLeft |-> relayDrive == 2'h0 && !beeper && !alarmLed)
    else $error("outputs active after reset");
  beep_cause_a: assert property ($rose(beeper) |-> $past(sampleValid) != 4'h0)
    else $error("beeper rose without a sample");
  beep_quiet_a: assert property ($changed(beeper) |-> evtAge_q <= 3'h3)
    else $error("beeper moved with no cause");
  relay_cause_a: assert property ($changed(relayDrive) |-> evtAge_q <= 3'h3)
    else $error("relay moved with no cause");
  msg_display_a: assert property (showAlarmMsg |-> displayActive)
    else $error("status message with panel idle");
  msg_blink_a: assert property ({7'h0, msgRun_q} <= BLINK_CYCLES)
    else $error("status message does not alternate");
endmodule

bind iar_alarm_relay iar_alarm_relay_assertions #(.BLINK_CYCLES(BLINK_CYCLES)) chk_inst (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sampleValid(sampleValid), .reading(reading), .displayedInput(displayedInput),
  .displayActive(displayActive), .alarmLed(alarmLed), .beeper(beeper),
  .showAlarmMsg(showAlarmMsg), .relayDrive(relayDrive));

/* File: tb/iar_far_side.sv */
// Far-side model: relay contacts, alarm lamp and beeper
`timescale 1ns/1ps
module iar_far_side
(
  input wire logic [1:0] relayDrive, // Coil drive
  input wire logic alarmLed, // Lamp drive
  input wire logic beeper, // Beeper drive
  output logic [1:0] noClosed, // Normally-open contact closed
  output logic [1:0] ncClosed, // Normally-closed contact closed
  output logic lampLit, // Lamp state
  output logic hornOn // Beeper sounding
);
  // A de-energised coil leaves NO open and NC closed
  assign noClosed = relayDrive;
  assign ncClosed = ~relayDrive;
  assign lampLit = alarmLed;
  assign hornOn = beeper;
endmodule

/* File: tb/iar_alarm_relay_tb.sv */
// Testbench for the input alarm and relay logic
`timescale 1ns/1ps
module iar_alarm_relay_tb;
  import iar_pkg::*;
  logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, alarmLed, beeper, showAlarmMsg;
  logic displayActive, lampLit, hornOn, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sampleValid;
  logic [4*VAL_W-1:0] reading;
  logic [1:0] displayedInput, relayDrive, noClosed, ncClosed;
  logic [2:0] seen;
  int error_cnt = 0;
  int checks = 0;
  localparam logic [23:0] LO = 24'h100000;

  iar_alarm_relay #(.BLINK_CYCLES(4)) iar_alarm_relay_inst (.mclk(mclk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleValid(sampleValid), .reading(reading), .displayedInput(displayedInput),
    .displayActive(displayActive), .alarmLed(alarmLed), .beeper(beeper), .showAlarmMsg(showAlarmMsg),
    .relayDrive(relayDrive));
  iar_far_side iar_far_side_inst (.relayDrive(relayDrive), .alarmLed(alarmLed), .beeper(beeper),
    .noClosed(noClosed), .ncClosed(ncClosed), .lampLit(lampLit), .hornOn(hornOn));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========
  // Tasks
  function automatic logic [11:0] ad(input int i, input logic [11:0] off);
    return 12'(i) * IN_STRIDE + off;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge mclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic smp(input logic [23:0] v);
    @(posedge mclk);
    reading[VAL_W-1:0] <= v;
    sampleValid <= 4'h1;
    @(posedge mclk);
    sampleValid <= 4'h0;
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && checks > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge mclk);
    error_cnt++;
    end_sim();
  end

  // ==========
  // Tests
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sampleValid = 4'h0;
    reading = '0;
    displayedInput = 2'h0;
    displayActive = 1'b1;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rdc(ad(i, OFF_IN_CFG), {28'h0, CFG_RST});
      rdc(ad(i, OFF_IN_LOW), {8'h0, LOW_SP_RST});
      rdc(ad(i, OFF_IN_HIGH), {8'h0, HIGH_SP_RST});
      rdc(ad(i, OFF_IN_DB), {8'h0, DEADBAND_RST});
    end
    rdc(OFF_RELAY0, 32'h20);
    rdc(OFF_RELAY1, 32'h20);
    chk({30'h0, ncClosed}, 32'h3);
    rdc(12'hffc, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(ad(1, OFF_IN_MAX), 32'h100000);
    wr(ad(1, OFF_IN_HIGH), 32'h200000);
    rdc(ad(1, OFF_IN_HIGH), 32'h100000);
    wr(ad(0, OFF_IN_CFG), 32'h7);
    chk({31'h0, lampLit}, 32'h1);
    // Both relays watch input A: one the high alarm, one the low
    wr(OFF_RELAY0, 32'h12);
    wr(OFF_RELAY1, 32'h02);
    smp(HIGH_SP_RST);
    rdc(OFF_IN_STAT, 32'h0);
    reading[VAL_W-1:0] <= HIGH_SP_RST + 24'h1;
    rdc(OFF_IN_STAT, 32'h0);
    smp(HIGH_SP_RST + 24'h1);
    rdc(OFF_IN_STAT, 32'h2);
    chk({30'h0, noClosed}, 32'h1);
    chk({31'h0, hornOn}, 32'h1);
    seen = 3'h0;
    repeat (12)
    begin
      @(posedge mclk);
      seen = seen | {showAlarmMsg, !showAlarmMsg, !lampLit};
    end
    chk({29'h0, seen}, 32'h7);
    // A panel showing a quiet input keeps showing the reading
    displayedInput <= 2'h1;
    seen = 3'h0;
    repeat (10)
    begin
      @(posedge mclk);
      seen[0] = seen[0] | showAlarmMsg;
    end
    chk({29'h0, seen}, 32'h0);
    displayedInput <= 2'h0;
    wr(OFF_ALARM_CTL, 32'h2);
    chk({31'h0, hornOn}, 32'h0);
    smp(HIGH_SP_RST - DEADBAND_RST + 24'h1);
    rdc(OFF_IN_STAT, 32'h2);
    smp(HIGH_SP_RST - DEADBAND_RST);
    rdc(OFF_IN_STAT, 32'h0);
    chk({30'h0, noClosed}, 32'h0);
    wr(ad(0, OFF_IN_LOW), {8'h0, LO});
    smp(LO);
    rdc(OFF_IN_STAT, 32'h0);
    smp(LO - 24'h1);
    rdc(OFF_IN_STAT, 32'h1);
    chk({30'h0, noClosed}, 32'h2);
    wr(OFF_RELAY0, 32'h22);
    chk({30'h0, noClosed}, 32'h3);
    smp(LO + DEADBAND_RST - 24'h1);
    rdc(OFF_IN_STAT, 32'h1);
    smp(LO + DEADBAND_RST);
    rdc(OFF_IN_STAT, 32'h0);
    wr(OFF_RELAY1, 32'h01);
    chk({30'h0, noClosed}, 32'h2);
    wr(OFF_RELAY1, 32'h00);
    chk({30'h0, ncClosed}, 32'h3);
    // Latched alarm survives a declined reset request
    wr(ad(0, OFF_IN_CFG), 32'hf);
    smp(HIGH_SP_RST + 24'h1);
    smp(24'h200000);
    rdc(OFF_IN_STAT, 32'h2);
    wr(OFF_ALARM_CTL, 32'h0);
    rdc(OFF_IN_STAT, 32'h2);
    wr(OFF_ALARM_CTL, 32'h1);
    rdc(OFF_IN_STAT, 32'h0);
    // Relay 1 moves to the high alarm of input B
    wr(ad(1, OFF_IN_CFG), 32'h1);
    wr(OFF_RELAY1, 32'h16);
    @(posedge mclk);
    reading[2*VAL_W-1:VAL_W] <= 24'h100001;
    sampleValid <= 4'h2;
    @(posedge mclk);
    sampleValid <= 4'h0;
    rdc(ad(1, OFF_IN_STAT), 32'h2);
    chk({30'h0, noClosed}, 32'h2);
    // Reset in mid-run returns relays, lamp and settings to their defaults
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    chk({30'h0, ncClosed}, 32'h3);
    chk({31'h0, lampLit}, 32'h0);
    rdc(OFF_RELAY1, 32'h20);
    rdc(ad(1, OFF_IN_HIGH), {8'h0, HIGH_SP_RST});
    end_sim();
  end
endmodule
